/* File: core/epti_pkg.sv */
// Package for the egress source-VLAN-ID tag insertion block.
// Holds register offsets, field layout, reset values and port counts.
// Assumes an 8-bit register address space and 8-bit register data.
`default_nettype none

package epti_pkg;

    // ************************************************************
    // Port counts and widths
    // ************************************************************
    // Switch ports numbered 1 to 5
    localparam int NUM_PORTS = 5;
    // Register address and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // Insertion control bits per ingress port, one per other egress port
    localparam int CTRL_W = 4;
    // Width of a port number
    localparam int PNUM_W = 3;
    // Width of a VLAN ID
    localparam int VID_W = 12;

    // ************************************************************
    // Per-port insertion control register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_P1_INS_CTRL = 8'hb0;
    localparam logic [ADDR_W-1:0] OFS_P2_INS_CTRL = 8'hc0;
    localparam logic [ADDR_W-1:0] OFS_P3_INS_CTRL = 8'hd0;
    localparam logic [ADDR_W-1:0] OFS_P4_INS_CTRL = 8'he0;
    localparam logic [ADDR_W-1:0] OFS_P5_INS_CTRL = 8'hf0;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    // Insertion bits sit in [3:0]; [7:4] are reserved and read as zero
    localparam int INS_FIELD_LSB = 0;
    localparam logic [CTRL_W-1:0] INS_CTRL_RST = 4'h0;
    localparam logic [DATA_W-1:0] RD_DATA_RST = 8'h00;
    // Zero-extension of the reserved upper nibble on readback
    localparam logic [DATA_W-CTRL_W-1:0] RSVD_READ_VAL = 4'h0;

endpackage : epti_pkg

`default_nettype wire

/* File: core/epti_egress_map.sv */
// Combinational map from one ingress port's relative control bits
// to an absolute egress port mask.
// Assumes the ingress port number is 1..5; any other value maps to none.
`default_nettype none

module epti_egress_map #(
    parameter int NUM_PORTS = epti_pkg::NUM_PORTS
) (
    // Ingress port number, 1-based
    input wire logic [epti_pkg::PNUM_W-1:0] src_port,
    // Relative control bits: [0] lowest other egress ... [3] highest
    input wire logic [epti_pkg::CTRL_W-1:0] ctrl,
    // Absolute egress mask: bit g stands for egress port g+1
    output logic [NUM_PORTS-1:0] egress_map
);

    // Control bits lined up for egress ports below the ingress port
    logic [NUM_PORTS-1:0] ctrl_below;
    // Control bits shifted up one for egress ports above the ingress port
    logic [NUM_PORTS-1:0] ctrl_above;

    assign ctrl_below = {1'b0, ctrl};
    assign ctrl_above = {ctrl, 1'b0};

    // ************************************************************
    // Relative position decode, one slice per egress port
    // ************************************************************
    // The ingress port itself is skipped, so the relative index
    // is the egress number minus one below it and minus two above it.
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_egress
        // Egress port number of this slice
        localparam logic [epti_pkg::PNUM_W-1:0] EG_NUM = epti_pkg::PNUM_W'(g + 1);
        always_comb begin
            if (src_port == 3'h0 || src_port > 3'(NUM_PORTS)) begin
                // Unknown ingress port never gets insertion
                egress_map[g] = 1'b0;
            end else if (EG_NUM < src_port) begin
                egress_map[g] = ctrl_below[g];
            end else if (EG_NUM > src_port) begin
                egress_map[g] = ctrl_above[g];
            end else begin
                // No frame is forwarded back out of its own port
                egress_map[g] = 1'b0;
            end
        end
    end

endmodule : epti_egress_map

`default_nettype wire

/* File: core/epti_top.sv */
// Top of the egress source-VLAN-ID tag insertion block.
// Holds the five per-port insertion control registers and, per frame,
// decides on which egress ports the source port's default VLAN ID is inserted.
// Assumes register accesses and frame lookups come from logic on CLK_SYS.
// Assumes the global enable is a level from a register on the same clock.
// Assumes frame lookups are one-cycle pulses; there is no back-pressure.
//
// Summary of operation
// - Bit 2: tag second-highest other egress port
// - Bit 1: tag second-lowest other egress port
// - Bit 0: tag lowest other egress port
// - Global enable gates every per-port insertion
// - Bit 3: tag highest other egress port
`default_nettype none

module epti_top #(
    parameter int NUM_PORTS = epti_pkg::NUM_PORTS
) (
    // System clock, 100 MHz
    input wire logic CLK_SYS,
    // Synchronous reset, active high
    input wire logic RST,
    // Global insertion enable, from bit 2 of the global register 135
    input wire logic GLOBAL_PVID_INS_EN,
    // Register write strobe, one-cycle pulse
    input wire logic REG_WR,
    // Register read strobe, one-cycle pulse
    input wire logic REG_RD,
    // Register byte address
    input wire logic [epti_pkg::ADDR_W-1:0] REG_ADDR,
    // Register write data
    input wire logic [epti_pkg::DATA_W-1:0] REG_WDATA,
    // Register read data, valid with REG_RVALID
    output logic [epti_pkg::DATA_W-1:0] REG_RDATA,
    // Read answer pulse, one cycle after REG_RD
    output logic REG_RVALID,
    // Frame lookup request, one-cycle pulse
    input wire logic FRM_VALID,
    // Ingress port number of the frame, 1..5
    input wire logic [epti_pkg::PNUM_W-1:0] FRM_SRC_PORT,
    // Egress ports the frame is forwarded to, bit g is port g+1
    input wire logic [NUM_PORTS-1:0] FRM_DST_MASK,
    // Frame already carried a VLAN tag on ingress
    input wire logic FRM_TAGGED,
    // Default VLAN ID of the frame's ingress port
    input wire logic [epti_pkg::VID_W-1:0] FRM_PVID,
    // Lookup answer pulse, one cycle after FRM_VALID
    output logic INS_VALID,
    // Egress ports on which the tag is to be inserted
    output logic [NUM_PORTS-1:0] INS_MASK,
    // VLAN ID to insert, the ingress port's default
    output logic [epti_pkg::VID_W-1:0] INS_VID
);

    // ************************************************************
    // Register storage
    // ************************************************************
    // Insertion control nibble per ingress port, index 0 is port 1
    logic [epti_pkg::CTRL_W-1:0] ins_ctrl_reg [NUM_PORTS];
    // Offsets of the per-port registers, in port order
    logic [epti_pkg::ADDR_W-1:0] ofs_tab [NUM_PORTS];
    // Read mux result
    logic [epti_pkg::DATA_W-1:0] rdata_next;
    // Control nibble selected by the frame's ingress port
    logic [epti_pkg::CTRL_W-1:0] sel_ctrl;
    // Absolute egress mask from the relative bits
    logic [NUM_PORTS-1:0] egress_map;
    // Insertion mask before registering
    logic [NUM_PORTS-1:0] ins_mask_next;

    // Offset table kept as nets so write and read decode share one map
    assign ofs_tab[0] = epti_pkg::OFS_P1_INS_CTRL;
    assign ofs_tab[1] = epti_pkg::OFS_P2_INS_CTRL;
    assign ofs_tab[2] = epti_pkg::OFS_P3_INS_CTRL;
    assign ofs_tab[3] = epti_pkg::OFS_P4_INS_CTRL;
    assign ofs_tab[4] = epti_pkg::OFS_P5_INS_CTRL;

    // ************************************************************
    // Register writes
    // ************************************************************
    // Writes to reserved bits [7:4] are dropped; they always read zero
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_reg
        always_ff @(posedge CLK_SYS) begin
            if (RST) begin
                ins_ctrl_reg[p] <= epti_pkg::INS_CTRL_RST;
            end else if (REG_WR && REG_ADDR == ofs_tab[p]) begin
                ins_ctrl_reg[p] <= REG_WDATA[epti_pkg::INS_FIELD_LSB +: epti_pkg::CTRL_W];
            end
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    // Unmapped addresses answer with zero rather than stale data
    // A write and a read of one register in one cycle return the old value
    always_comb begin
        rdata_next = epti_pkg::RD_DATA_RST;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (REG_ADDR == ofs_tab[p]) begin
                rdata_next = {epti_pkg::RSVD_READ_VAL, ins_ctrl_reg[p]};
            end
        end
    end

    // Read answer registered so the outputs come from flops
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            REG_RDATA <= epti_pkg::RD_DATA_RST;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_next;
            end
        end
    end

    // ************************************************************
    // Per-frame insertion decision
    // ************************************************************
    // Pick the ingress port's control nibble; unknown ports give zero
    always_comb begin
        sel_ctrl = epti_pkg::INS_CTRL_RST;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (FRM_SRC_PORT == 3'(p + 1)) begin
                sel_ctrl = ins_ctrl_reg[p];
            end
        end
    end

    epti_egress_map #(
        .NUM_PORTS(NUM_PORTS)
    ) u_map (
        .src_port(FRM_SRC_PORT),
        .ctrl(sel_ctrl),
        .egress_map(egress_map)
    );

    // gate by enable and tag
    // A tagged frame keeps its own tag, so it never gets a second one
    // Limitation: the decision uses the nibble as of the last finished write
    assign ins_mask_next = (GLOBAL_PVID_INS_EN && !FRM_TAGGED) ? (egress_map & FRM_DST_MASK) : '0;

    // Answer one cycle after the request; mask is cleared between frames
    // INS_VID holds its value so downstream logic may pick it up late
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            INS_VALID <= 1'b0;
            INS_MASK <= '0;
            INS_VID <= '0;
        end else begin
            INS_VALID <= FRM_VALID;
            INS_MASK <= FRM_VALID ? ins_mask_next : '0;
            if (FRM_VALID) begin
                INS_VID <= FRM_PVID;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // Untagged request with enable, sampled in the request cycle
    logic req_ok;
    assign req_ok = FRM_VALID && GLOBAL_PVID_INS_EN && !FRM_TAGGED;

    p1_second_high_a: assert property (
        req_ok && FRM_SRC_PORT == 3'h1 && ins_ctrl_reg[0][2] && FRM_DST_MASK[3] |=> INS_MASK[3])
        else $error("Port 1 bit 2 did not tag egress 4");
    p5_second_high_a: assert property (
        req_ok && FRM_SRC_PORT == 3'h5 && ins_ctrl_reg[4][2] && FRM_DST_MASK[2] |=> INS_MASK[2])
        else $error("Port 5 bit 2 did not tag egress 3");
    p3_second_low_a: assert property (
        req_ok && FRM_SRC_PORT == 3'h3 && FRM_DST_MASK[1] |=> INS_MASK[1] == $past(ins_ctrl_reg[2][1]))
        else $error("Port 3 bit 1 did not steer egress 2");
    lowest_egress_a: assert property (
        req_ok && FRM_SRC_PORT == 3'h4 && FRM_DST_MASK[0] |=> INS_MASK[0] == $past(ins_ctrl_reg[3][0]))
        else $error("Port 4 bit 0 did not steer egress 1");
    global_gate_a: assert property (
        FRM_VALID && !GLOBAL_PVID_INS_EN |=> INS_VALID && INS_MASK == '0)
        else $error("Insertion while global enable low");
    p4_highest_a: assert property (
        req_ok && FRM_SRC_PORT == 3'h4 && ins_ctrl_reg[3][3] && FRM_DST_MASK[4] |=> INS_MASK[4])
        else $error("Port 4 bit 3 did not tag egress 5");
    tagged_frame_a: assert property (
        FRM_VALID && FRM_TAGGED |=> INS_MASK == '0)
        else $error("Tagged frame got an inserted tag");
    // Only forwarded ports may be tagged
    mask_subset_a: assert property (
        FRM_VALID |=> (INS_MASK & ~$past(FRM_DST_MASK)) == '0)
        else $error("Tag on a non-forwarded port");
    // Own port checked only for valid port numbers, so the index stays in range
    own_port_a: assert property (
        FRM_VALID && FRM_SRC_PORT >= 3'h1 && FRM_SRC_PORT <= 3'h5
        |=> INS_MASK[$past(FRM_SRC_PORT) - 3'h1] == 1'b0)
        else $error("Tag on the frame's own port");
    // Lookup answer exactly one cycle late and carrying the request's VID
    lookup_latency_a: assert property (
        !$past(RST) |-> INS_VALID == $past(FRM_VALID) && (!$past(FRM_VALID) || INS_VID == $past(FRM_PVID)))
        else $error("Lookup answer late or with wrong VID");
    // Read answer exactly one cycle after the read strobe
    read_latency_a: assert property (
        !$past(RST) |-> REG_RVALID == $past(REG_RD))
        else $error("Read answer not one cycle after request");
    // Reserved upper nibble always reads as zero
    rsvd_zero_a: assert property (
        REG_RVALID |-> REG_RDATA[7:4] == 4'h0)
        else $error("Reserved read bits not zero");
    // Write followed by read of one register returns the kept nibble
    read_back_a: assert property (
        REG_WR && REG_ADDR == epti_pkg::OFS_P2_INS_CTRL ##1 REG_RD && REG_ADDR == epti_pkg::OFS_P2_INS_CTRL
        |=> REG_RVALID && REG_RDATA == {4'h0, $past(REG_WDATA[3:0], 2)})
        else $error("Readback differs from write");

    // Cover points for the main scenarios
    tag_any_c: cover property (INS_VALID && INS_MASK != '0);
    tag_all_c: cover property (INS_VALID && $countones(INS_MASK) == 4);
    gated_c: cover property (FRM_VALID && !GLOBAL_PVID_INS_EN && sel_ctrl != '0);
    tagged_c: cover property (FRM_VALID && FRM_TAGGED && egress_map != '0);

endmodule : epti_top

`default_nettype wire

/* File: bench/epti_top_tb.sv */
// Self-checking bench for the egress tag insertion block.
// Assumes epti_pkg, epti_egress_map and epti_top are compiled first.
`default_nettype none

module epti_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Stimulus, outputs and scoreboard state
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic frm_valid = 1'b0;
    logic frm_tagged = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [2:0] frm_src = 3'h0;
    logic [4:0] frm_dst = 5'h00;
    logic [11:0] frm_pvid = 12'h000;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic ins_valid;
    logic [4:0] ins_mask;
    logic [11:0] ins_vid;
    // Expected read data and expected {mask, vid}, oldest first
    logic [7:0] rd_q[$];
    logic [16:0] frm_q[$];
    // Shadow of the five control nibbles, updated as writes are issued
    logic [3:0] shadow [1:5];
    int n_mismatch = 0;
    int check_count = 0;

    // Free-running 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    epti_top u_epti_top (.CLK_SYS(clk_sys), .RST(rst), .GLOBAL_PVID_INS_EN(en), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .FRM_VALID(frm_valid), .FRM_SRC_PORT(frm_src), .FRM_DST_MASK(frm_dst),
        .FRM_TAGGED(frm_tagged), .FRM_PVID(frm_pvid), .INS_VALID(ins_valid), .INS_MASK(ins_mask),
        .INS_VID(ins_vid));

    // Single compare point; x or z never passes
    task check(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Index 6 stands for an unmapped address
    function automatic logic [7:0] ofs(input int i);
        case (i)
            1: return epti_pkg::OFS_P1_INS_CTRL;
            2: return epti_pkg::OFS_P2_INS_CTRL;
            3: return epti_pkg::OFS_P3_INS_CTRL;
            4: return epti_pkg::OFS_P4_INS_CTRL;
            5: return epti_pkg::OFS_P5_INS_CTRL;
            default: return 8'hb1;
        endcase
    endfunction : ofs

    function automatic logic [4:0] exp_mask(input int p, input logic [4:0] d, input logic t, input logic e);
        logic [4:0] m;
        m = 5'h00;
        if (p >= 1 && p <= 5) begin
            for (int g = 1; g <= 5; g++) begin
                // Own port never; lower ports use bit g-1, higher ones bit g-2
                if (g != p) m[g-1] = (g < p) ? shadow[p][g-1] : shadow[p][g-2];
            end
        end
        return (e && !t) ? (m & d) : 5'h00;
    endfunction : exp_mask

    // Drivers: one request per task, strobes held for one edge only
    task wr(input int i, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_rd, frm_valid} <= 3'b100;
        reg_addr <= ofs(i);
        reg_wdata <= d;
        // Upper nibble is reserved, so only [3:0] is kept
        if (i <= 5) shadow[i] = d[3:0];
    endtask : wr

    task rd(input int i);
        @(posedge clk_sys);
        {reg_wr, reg_rd, frm_valid} <= 3'b010;
        reg_addr <= ofs(i);
        rd_q.push_back((i <= 5) ? {4'h0, shadow[i]} : 8'h00);
    endtask : rd

    task frm(input int p, input logic [4:0] d, input logic t, input logic e, input logic [11:0] v);
        @(posedge clk_sys);
        {reg_wr, reg_rd, frm_valid} <= 3'b001;
        {frm_src, frm_dst, frm_tagged, en, frm_pvid} <= {p[2:0], d, t, e, v};
        frm_q.push_back({exp_mask(p, d, t, e), v});
    endtask : frm

    // Ends the run; also the exit of a wait that ran out
    task final_report;
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report

    // Lets outstanding answers arrive, bounded
    task drain(input string name);
        @(posedge clk_sys);
        {reg_wr, reg_rd, frm_valid} <= 3'b000;
        for (int n = 0; n < 20 && (rd_q.size() + frm_q.size()) > 0; n++) @(posedge clk_sys);
        if ((rd_q.size() + frm_q.size()) > 0) begin
            n_mismatch++;
            $display("[FAIL] %0t answers missing in %s", $time, name);
            final_report();
        end else begin
            $display("test done: %s", name);
        end
    endtask : drain

    // Monitor: every answer takes the oldest note
    always @(posedge clk_sys) begin
        if (!rst && reg_rvalid === 1'b1) begin
            if (rd_q.size() == 0) check(17'h1, 17'h0);
            else check({9'h000, reg_rdata}, {9'h000, rd_q.pop_front()});
        end
        if (!rst && ins_valid === 1'b1) begin
            if (frm_q.size() == 0) check(17'h1, 17'h0);
            else check({ins_mask, ins_vid}, frm_q.pop_front());
        end else if (!rst) begin
            // No insertion outside an answer cycle
            check({12'h000, ins_mask}, 17'h0);
        end
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        r = $urandom(32'h37b2);
        for (int i = 1; i <= 5; i++) shadow[i] = 4'h0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values of all five registers and an unmapped read
        for (int i = 1; i <= 6; i++) rd(i);
        drain("reset values");
        // Write then read back to back, reserved bits and unmapped place
        for (int i = 6; i >= 1; i--) begin
            r = $urandom;
            wr(i, r[7:0]);
            rd(i);
        end
        for (int i = 1; i <= 6; i++) rd(i);
        drain("register access");
        // Random mix of writes, reads and lookups with the enable toggling
        for (int k = 0; k < 600; k++) begin
            r = $urandom;
            case ($urandom_range(3, 0))
                0: wr($urandom_range(6, 1), r[7:0]);
                1: rd($urandom_range(6, 1));
                default: frm(int'(r[2:0]), r[7:3], r[8] & r[11], r[10:9] != 2'b00, r[23:12]);
            endcase
        end
        drain("random mix");
        final_report();
    end
endmodule : epti_top_tb

`default_nettype wire
